// file: logic/drop_bus_top.sv
// drop bus output block: AXI4-Lite registers, interrupts, per-channel pins
// assumes one link clock pin shared by all channels and a clk-domain byte source
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module drop_bus_top
#(
   parameter int NUM_CH = drop_bus_pkg::NUM_CH_DEF,
   parameter int ADDR_W = drop_bus_pkg::ADDR_W_DEF
)
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // link clock pin
   input wire logic linkClkIn,
   // byte sources
   input wire drop_bus_pkg::drop_byte_s [NUM_CH-1:0] srcByte,
   input wire logic [NUM_CH-1:0] srcValid,
   output logic [NUM_CH-1:0] srcTaken,
   // line-side signals
   input wire drop_bus_pkg::tx_line_s [NUM_CH-1:0] txLine,
   // drop bus pins
   output drop_bus_pkg::drop_pins_s [NUM_CH-1:0] dropPins,
   // interrupt
   output logic irq
);
   import drop_bus_pkg::*;

   localparam int IRQ_W = 2 * NUM_CH;

   // one-hot register select: {count, live, mask, status, control}
   typedef logic [4:0] reg_sel_t;

   function automatic reg_sel_t decodeReg(input logic [ADDR_W-1:0] a);
      logic [9:0] idx;
      logic cntHit;
      idx = 10'(a[ADDR_W-1:2]);
      cntHit = (idx[9:2] == IDX_CNT0[9:2]) && (32'(idx[1:0]) < NUM_CH);
      decodeReg = {cntHit, idx == IDX_LIVE, idx == IDX_IRQ_MASK, idx == IDX_IRQ_STAT, idx == IDX_CTL};
   endfunction

   // control and interrupt registers
   logic [7:0] ctl_q, ctl_d;
   logic [IRQ_W-1:0] irqStat_q, irqStat_d, irqMask_q, irqMask_d;
   logic irq_q, irq_d;
   logic [7:0] byteCnt_q [NUM_CH];

   // write channel state
   logic awFull_q, awFull_d, wFull_q, wFull_d;
   logic [ADDR_W-1:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic awready_q, wready_q, bvalid_q, bvalid_d;
   logic [1:0] bresp_q;

   // read channel state
   logic arready_q, rvalid_q, rvalid_d;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   // next values of the bus-side registers
   logic awready_d, wready_d, arready_d, wrBad, rdBad;
   logic [ADDR_W-1:0] awAddr_d;
   logic [31:0] wData_d, rdata_d;
   logic [3:0] wStrb_d;
   logic [1:0] bresp_d, rresp_d;

   // decode and strobes
   logic awHs, wHs, arHs, doWrite;
   reg_sel_t wrSel, rdSel;
   logic wrCtl, wrStat, wrMask;
   logic [31:0] rdMux;
   logic [31:0] cntWord, ctlWord, statWord, maskWord, liveWord;
   logic [1:0] cntIdx;

   // per-channel wires
   logic linkRise, linkFall;
   logic [NUM_CH-1:0] busEnable, underrun, aisRise, aisLive;
   logic [IRQ_W-1:0] irqEvents, irqClear;
   drop_pins_s [NUM_CH-1:0] pinsW;
   logic [NUM_CH-1:0] takenW;

   assign awHs = s_axi_awvalid && awready_q;
   assign wHs = s_axi_wvalid && wready_q;
   assign arHs = s_axi_arvalid && arready_q;
   assign doWrite = awFull_q && wFull_q && !bvalid_q;

   assign wrSel = decodeReg(awAddr_q);
   assign rdSel = decodeReg(s_axi_araddr);
   assign wrCtl = doWrite && wrSel[0] && wStrb_q[0];
   assign wrStat = doWrite && wrSel[1] && wStrb_q[0];
   assign wrMask = doWrite && wrSel[2] && wStrb_q[0];

   // unmapped counter slots never index past the array
   assign cntIdx = (32'(s_axi_araddr[3:2]) < NUM_CH) ? s_axi_araddr[3:2] : 2'b00;
   assign cntWord = {24'h000000, byteCnt_q[cntIdx]};
   assign ctlWord = {24'h000000, ctl_q};
   assign statWord = {{(32 - IRQ_W){1'b0}}, irqStat_q};
   assign maskWord = {{(32 - IRQ_W){1'b0}}, irqMask_q};
   assign liveWord = {{(32 - NUM_CH){1'b0}}, aisLive};
   assign rdMux = rdSel[0] ? ctlWord :
                  rdSel[1] ? statWord :
                  rdSel[2] ? maskWord :
                  rdSel[3] ? liveWord :
                  rdSel[4] ? cntWord : 32'h00000000;

   // control register steers parity and bus enables
   assign ctl_d = wrCtl ? wData_q[7:0] : ctl_q;
   assign busEnable = ctl_q[CTL_EN_LSB +: NUM_CH];

   // sticky events: a set in the clear cycle wins
   assign irqEvents = {underrun, aisRise};
   assign irqClear = wrStat ? wData_q[IRQ_W-1:0] : '0;
   assign irqStat_d = (irqStat_q & ~irqClear) | irqEvents;
   assign irqMask_d = wrMask ? wData_q[IRQ_W-1:0] : irqMask_q;
   assign irq_d = |(irqStat_d & irqMask_d);

   // write and read handshake bookkeeping
   assign awFull_d = doWrite ? 1'b0 : (awFull_q || awHs);
   assign wFull_d = doWrite ? 1'b0 : (wFull_q || wHs);
   assign bvalid_d = doWrite ? 1'b1 : (bvalid_q && !s_axi_bready);
   assign rvalid_d = arHs ? 1'b1 : (rvalid_q && !s_axi_rready);
   assign awready_d = !awFull_d && !bvalid_d;
   assign wready_d = !wFull_d && !bvalid_d;
   assign arready_d = !rvalid_d;

   // captured request fields and responses
   assign awAddr_d = awHs ? s_axi_awaddr : awAddr_q;
   assign wData_d = wHs ? s_axi_wdata : wData_q;
   assign wStrb_d = wHs ? s_axi_wstrb : wStrb_q;
   assign wrBad = (wrSel == 5'h00) || wrSel[3] || wrSel[4];
   assign rdBad = rdSel == 5'h00;
   assign bresp_d = doWrite ? (wrBad ? RESP_SLVERR : RESP_OKAY) : bresp_q;
   assign rdata_d = arHs ? rdMux : rdata_q;
   assign rresp_d = arHs ? (rdBad ? RESP_SLVERR : RESP_OKAY) : rresp_q;

   link_edge_sync u_link_sync
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .asyncIn(linkClkIn),
      .rise(linkRise),
      .fall(linkFall)
   );

   generate
      for (genvar ch = 0; ch < NUM_CH; ch++)
      begin : g_ch
         drop_chan_out u_chan
         (
            .clk(clk),
            .sys_rst(sys_rst),
            .rise(linkRise),
            .fall(linkFall),
            .busEnable(busEnable[ch]),
            .parityOdd(ctl_q[CTL_ODD_BIT]),
            .parityAll(ctl_q[CTL_ALL_BIT]),
            .srcByte(srcByte[ch]),
            .srcValid(srcValid[ch]),
            .txLine(txLine[ch]),
            .pins(pinsW[ch]),
            .srcTaken(takenW[ch]),
            .underrun(underrun[ch]),
            .aisRise(aisRise[ch]),
            .aisLive(aisLive[ch])
         );

         // wrapping count of source bytes taken on the channel
         always_ff @(posedge clk)
         begin
            if (sys_rst)
               byteCnt_q[ch] <= CNT_RESET;
            else if (takenW[ch])
               byteCnt_q[ch] <= byteCnt_q[ch] + 8'h01;
         end
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         ctl_q <= CTL_RESET;
      else
         ctl_q <= ctl_d;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         irqStat_q <= '0;
      else
         irqStat_q <= irqStat_d;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         irqMask_q <= IRQ_W'(IRQ_MASK_RESET);
      else
         irqMask_q <= irqMask_d;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         irq_q <= 1'b0;
      else
         irq_q <= irq_d;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         awFull_q <= 1'b0;
      else
         awFull_q <= awFull_d;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         wFull_q <= 1'b0;
      else
         wFull_q <= wFull_d;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         awready_q <= 1'b0;
      else
         awready_q <= awready_d;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         wready_q <= 1'b0;
      else
         wready_q <= wready_d;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         bvalid_q <= 1'b0;
      else
         bvalid_q <= bvalid_d;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         bresp_q <= RESP_OKAY;
      else
         bresp_q <= bresp_d;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         awAddr_q <= '0;
      else
         awAddr_q <= awAddr_d;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         wData_q <= 32'h00000000;
      else
         wData_q <= wData_d;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         wStrb_q <= 4'h0;
      else
         wStrb_q <= wStrb_d;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         arready_q <= 1'b0;
      else
         arready_q <= arready_d;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rvalid_q <= 1'b0;
      else
         rvalid_q <= rvalid_d;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rdata_q <= 32'h00000000;
      else
         rdata_q <= rdata_d;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rresp_q <= RESP_OKAY;
      else
         rresp_q <= rresp_d;
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign dropPins = pinsW;
   assign srcTaken = takenW;
   assign irq = irq_q;
endmodule
`default_nettype wire

// file: logic/drop_bus_pkg.sv
// constants, field layouts and carrier types of the drop bus output block
// assumes the per-channel byte source and the line-side framer run on clk
package drop_bus_pkg;

   localparam int NUM_CH_DEF = 3;
   localparam int ADDR_W_DEF = 12;

   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_CTL = 10'h13B;
   localparam logic [9:0] IDX_IRQ_STAT = 10'h140;
   localparam logic [9:0] IDX_IRQ_MASK = 10'h141;
   localparam logic [9:0] IDX_LIVE = 10'h142;
   localparam logic [9:0] IDX_CNT0 = 10'h144;

   // control register fields
   localparam int CTL_ODD_BIT = 0;
   localparam int CTL_ALL_BIT = 1;
   localparam int CTL_EN_LSB = 2;
   localparam logic [7:0] CTL_RESET = 8'h1C;
   localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
   localparam logic [7:0] CNT_RESET = 8'h00;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // bus clock rates of the two modes and the sampling clock
   localparam int SYS_CLK_KHZ = 40000;
   localparam int BUS_CLK_3CH_KHZ = 19440;
   localparam int BUS_CLK_1CH_KHZ = 6480;
   localparam int SYNC_STAGES = 3;

   typedef struct packed {
      logic [7:0] data;
      logic toh;
      logic c1;
      logic j1;
      logic ais;
   } drop_byte_s;

   typedef struct packed {
      logic [7:0] data;
      logic payload;
      logic phase;
      logic parity;
      logic alarm;
      logic busClk;
   } drop_pins_s;

   typedef struct packed {
      logic clk;
      logic pos;
      logic neg;
   } tx_line_s;

endpackage

// file: logic/link_edge_sync.sv
// three-stage synchroniser with edge detection for the sampled link clock
// assumes the input is asynchronous to clk and far slower than it
`timescale 1ns/10ps
`default_nettype none
module link_edge_sync
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // asynchronous level
   input wire logic asyncIn,
   // clk-domain results
   output logic rise,
   output logic fall
);
   import drop_bus_pkg::*;

   logic s1_q, s2_q, s3_q, level_q;
   logic change;

   // a change counts once stages two and three agree
   assign change = (s2_q == s3_q) && (s3_q != level_q);
   assign rise = change && s3_q;
   assign fall = change && !s3_q;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
      end
      else
      begin
         s1_q <= asyncIn;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (change)
            level_q <= s3_q;
      end
   end
endmodule
`default_nettype wire

// file: logic/drop_chan_out.sv
// one channel of drop bus pins: byte, indicators, parity, alarm, bus clock
// assumes rise/fall pulses from the link synchroniser and a same-clock source
`timescale 1ns/10ps
`default_nettype none
module drop_chan_out
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // timing and configuration
   input wire logic rise,
   input wire logic fall,
   input wire logic busEnable,
   input wire logic parityOdd,
   input wire logic parityAll,
   // byte source
   input wire drop_bus_pkg::drop_byte_s srcByte,
   input wire logic srcValid,
   // line-side signals used while the bus is off
   input wire drop_bus_pkg::tx_line_s txLine,
   // pins and events
   output drop_bus_pkg::drop_pins_s pins,
   output logic srcTaken,
   output logic underrun,
   output logic aisRise,
   output logic aisLive
);
   import drop_bus_pkg::*;

   drop_pins_s pins_q, pins_d, busNext;
   logic aisLive_q, taken_q, underrun_q, aisRise_q;
   logic nextPayload, nextPhase, nextAlarm, parityBase;
   logic [7:0] nextData;
   logic present;

   assign present = rise && busEnable;
   assign nextData = srcValid ? srcByte.data : 8'h00;
   // C1 is overhead, J1 is payload, whatever the source says
   assign nextPayload = srcValid && !srcByte.c1 && (srcByte.j1 || !srcByte.toh);
   assign nextPhase = srcValid && (srcByte.c1 || srcByte.j1);
   assign nextAlarm = srcValid && srcByte.ais;
   // parity over the very values driven this cycle
   assign parityBase = ^nextData ^ (parityAll ? (nextPayload ^ nextPhase) : 1'b0);
   assign busNext = '{data: nextData, payload: nextPayload, phase: nextPhase,
                      parity: parityBase ^ parityOdd, alarm: nextAlarm, busClk: 1'b1};

   always_comb
   begin
      pins_d = pins_q;
      if (!busEnable)
      begin
         pins_d = '0;
         pins_d.phase = txLine.clk;
         pins_d.parity = txLine.pos;
         pins_d.alarm = txLine.neg;
      end
      else if (present)
         pins_d = busNext;
      else if (fall)
         pins_d.busClk = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pins_q <= '0;
         aisLive_q <= 1'b0;
         taken_q <= 1'b0;
         underrun_q <= 1'b0;
         aisRise_q <= 1'b0;
      end
      else
      begin
         pins_q <= pins_d;
         taken_q <= present && srcValid;
         underrun_q <= present && !srcValid;
         aisRise_q <= present && nextAlarm && !aisLive_q;
         if (present)
            aisLive_q <= nextAlarm;
         else if (!busEnable)
            aisLive_q <= 1'b0;
      end
   end

   assign pins = pins_q;
   assign srcTaken = taken_q;
   assign underrun = underrun_q;
   assign aisRise = aisRise_q;
   assign aisLive = aisLive_q;
endmodule
`default_nettype wire

// file: verif/drop_bus_asserts.sv
// checker for the channel 0 drop bus pins
// assumes it is bound onto drop_bus_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module drop_bus_asserts
#(
   parameter int NUM_CH = 3,
   parameter int ADDR_W = 12
)
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // watched ports
   input wire drop_bus_pkg::drop_byte_s [NUM_CH-1:0] srcByte,
   input wire logic [NUM_CH-1:0] srcValid,
   input wire drop_bus_pkg::drop_pins_s [NUM_CH-1:0] dropPins
);
   import drop_bus_pkg::*;
   drop_byte_s srcPrev_q;
   logic validPrev_q;
   drop_pins_s p;
   assign p = dropPins[0];
   // byte and valid as the design sampled them at the presenting edge
   always_ff @(posedge clk)
   begin
      srcPrev_q <= srcByte[0];
      validPrev_q <= srcValid[0] & ~sys_rst;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence sNew;
      $rose(p.busClk);
   endsequence
   sequence sTake;
      sNew ##0 validPrev_q;
   endsequence
   AST_DATA_MATCH: assert property (sTake |-> p.data == srcPrev_q.data)
      else $error("drop data differs from taken byte");
   AST_C1_MARK: assert property (sTake ##0 srcPrev_q.c1 |-> p.phase && !p.payload)
      else $error("c1 byte not marked");
   AST_J1_MARK: assert property (sTake ##0 (srcPrev_q.j1 && !srcPrev_q.c1) |-> p.phase && p.payload)
      else $error("j1 byte not marked");
   AST_PHASE_QUIET: assert property (sNew ##0 !(validPrev_q && (srcPrev_q.c1 || srcPrev_q.j1)) |-> !p.phase)
      else $error("phase high on other byte");
   AST_PHASE_HOLD: assert property (sNew ##0 p.phase |=> p.phase [*3])
      else $error("phase pulse cut short");
   AST_ALARM_SET: assert property (sTake ##0 srcPrev_q.ais |-> p.alarm)
      else $error("alarm missing on ais byte");
   AST_ALARM_CLEAR: assert property (sNew ##0 !(validPrev_q && srcPrev_q.ais) |-> !p.alarm)
      else $error("alarm high without ais");
   AST_PAYLOAD_TOH: assert property (sTake ##0 !(srcPrev_q.c1 || srcPrev_q.j1) |-> p.payload == !srcPrev_q.toh)
      else $error("payload level wrong");
   AST_DATA_EDGE: assert property ($changed(p.data) |-> sNew)
      else $error("data moved off bus clock rise");
endmodule
`default_nettype wire

// file: verif/drop_sink.sv
// drop side model: checks parity of every byte on channel 0
// assumes the bench tells it the parity setting in use
`timescale 1ns/10ps
`default_nettype none
module drop_sink
(
   // clock
   input wire logic clk,
   // pins and parity setting
   input wire drop_bus_pkg::drop_pins_s pins,
   input wire logic [1:0] mode,
   // failed byte count
   output var int errs
);
   import drop_bus_pkg::*;
   logic seen_q = 1'b0;
   int bad = 0;
   logic good;
   assign good = ((^{pins.data, mode[1] & pins.payload, mode[1] & pins.phase}) ^ mode[0]) === pins.parity;
   assign errs = bad;
   always @(posedge clk)
   begin
      seen_q <= pins.busClk;
      if (pins.busClk && !seen_q && !good)
         bad <= bad + 1;
   end
endmodule
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the drop bus output block
// assumes channel 0 carries the test stream and the checker is bound here
`timescale 1ns/10ps
`default_nettype none
module tb;
   import drop_bus_pkg::*;
   logic clk = 0, sys_rst = 1, linkClkIn = 0, irq;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, sinkMode = 0;
   drop_byte_s [2:0] srcByte = '0;
   logic [2:0] srcValid = 0, srcTaken;
   tx_line_s [2:0] txLine = '0;
   drop_pins_s [2:0] dropPins;
   int err_total = 0, n_compared = 0, sinkErrs;
   always #12.5 clk = ~clk;
   initial #37 forever #100 linkClkIn = ~linkClkIn;
   drop_bus_top dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .linkClkIn, .srcByte, .srcValid, .srcTaken, .txLine, .dropPins, .irq);
   drop_sink sink (.clk, .pins(dropPins[0]), .mode(sinkMode), .errs(sinkErrs));
   task automatic report_and_stop;
      if (err_total == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      n_compared++;
      if (ok !== 1'b1)
      begin
         err_total++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready)
            s_axi_awvalid <= 0;
         if (s_axi_wready)
            s_axi_wvalid <= 0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 0;
      chk(s_axi_bresp === r, "write response");
   endtask
   task automatic rdr(input logic [11:0] a, input logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready)
            s_axi_arvalid <= 0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 0;
      rd = s_axi_rdata;
      chk(s_axi_rresp === r, "read response");
   endtask
   // present one byte on channel 0 and compare the pins it produces
   task automatic send(input logic [11:0] v, input logic [1:0] m);
      drop_byte_s b;
      drop_pins_s e;
      b = drop_byte_s'(v);
      e.data = b.data;
      e.payload = b.c1 ? 1'b0 : (b.j1 | ~b.toh);
      e.phase = b.c1 | b.j1;
      e.parity = (^b.data) ^ (m[1] & (e.payload ^ e.phase)) ^ m[0];
      e.alarm = b.ais;
      e.busClk = 1'b1;
      @(posedge clk);
      srcByte[0] <= b;
      srcValid[0] <= 1'b1;
      do
      begin
         @(posedge clk);
         #1;
      end while (srcTaken[0] !== 1'b1);
      chk(dropPins[0] === e, "pins of presented byte");
      @(posedge clk);
      srcValid[0] <= 1'b0;
   endtask
   task automatic t_regs;
      rdr({IDX_CTL, 2'b00}, RESP_OKAY);
      chk(rd === {24'h000000, CTL_RESET}, "control reset value");
      rdr(12'h000, RESP_SLVERR);
      wr({IDX_LIVE, 2'b00}, 32'h00000007, RESP_SLVERR);
      rdr({IDX_IRQ_MASK, 2'b00}, RESP_OKAY);
      chk(rd === 32'h00000000, "mask reset value");
   endtask
   task automatic t_stream;
      logic [11:0] seq [5] = '{12'hA58, 12'h3CC, 12'h5A2, 12'h810, 12'hFF1};
      for (int m = 0; m < 4; m++)
      begin
         wr({IDX_CTL, 2'b00}, {24'h000000, CTL_RESET | 8'(m)}, RESP_OKAY);
         sinkMode <= 2'(m);
         for (int i = 0; i < 5; i++)
            send(seq[i], 2'(m));
      end
      rdr({IDX_LIVE, 2'b00}, RESP_OKAY);
      chk(rd === 32'h00000001, "live alarm after ais byte");
   endtask
   task automatic t_irq;
      rdr({IDX_IRQ_STAT, 2'b00}, RESP_OKAY);
      chk(rd[0] === 1'b1 && rd[3] === 1'b1, "status events");
      chk(irq === 1'b0, "irq while masked");
      wr({IDX_IRQ_MASK, 2'b00}, 32'h00000001, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk(irq === 1'b1, "irq not raised");
      wr({IDX_IRQ_STAT, 2'b00}, 32'h00000001, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk(irq === 1'b0, "irq not cleared");
      rdr({IDX_IRQ_STAT, 2'b00}, RESP_OKAY);
      chk(rd[0] === 1'b0, "status bit not cleared");
      rdr({IDX_CNT0, 2'b00}, RESP_OKAY);
      chk(rd === 32'h00000014, "bytes presented on channel 0");
      rdr({IDX_CNT0 + 10'h003, 2'b00}, RESP_SLVERR);
      chk(rd === 32'h00000000, "unmapped counter slot");
   endtask
   // channel 1 off: its pins carry the line signals
   task automatic t_disable;
      wr({IDX_CTL, 2'b00}, 32'h00000014, RESP_OKAY);
      sinkMode <= 2'h0;
      txLine[1] <= 3'b101;
      repeat (3) @(posedge clk);
      chk(dropPins[1] === 13'h00A, "line mode pins");
      txLine[1] <= 3'b010;
      repeat (3) @(posedge clk);
      chk(dropPins[1] === 13'h004, "line mode pins");
      chk({dropPins[2].data, dropPins[2].payload, dropPins[2].phase, dropPins[2].alarm} === 11'h000,
         "idle channel pins");
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      sys_rst <= 0;
      t_regs;
      t_stream;
      t_irq;
      t_disable;
      chk(sinkErrs === 0, "parity seen by drop side");
      report_and_stop;
   end
   initial
   begin
      #200000;
      err_total++;
      report_and_stop;
   end
endmodule
bind drop_bus_top drop_bus_asserts #(.NUM_CH(NUM_CH), .ADDR_W(ADDR_W)) chk_i (.clk, .sys_rst, .srcByte,
   .srcValid, .dropPins);
`default_nettype wire
